// ---- design/io_ctl_pkg.sv ----
package io_ctl_pkg;

  // Register byte offsets.
  localparam logic [7:0] OFF_IO_CONTROL = 8'h00;
  localparam logic [7:0] OFF_KEYBOARD_DATA = 8'h04;
  localparam logic [7:0] OFF_KEYBOARD_CONTROL = 8'h08;
  localparam logic [7:0] OFF_PORT_LINES = 8'h0C;
  localparam logic [7:0] OFF_IRQ_A_STATUS = 8'h10;
  localparam logic [7:0] OFF_IRQ_A_REQUEST = 8'h14;
  localparam logic [7:0] OFF_IRQ_A_MASK = 8'h18;

  // I/O control field positions.
  localparam int IOC_BIT_VBLANK = 7;
  localparam int IOC_BIT_EXT1 = 6;
  localparam int IOC_BIT_SENSE = 3;
  localparam int IOC_BIT_OD1 = 1;
  localparam int IOC_BIT_OD0 = 0;
  localparam logic [7:0] IOC_ONES_MASK = 8'h34;

  // Keyboard control field positions.
  localparam int KBC_BIT_TX_EMPTY = 7;
  localparam int KBC_BIT_TX_ACTIVE = 6;
  localparam int KBC_BIT_RX_FULL = 5;
  localparam int KBC_BIT_RX_ACTIVE = 4;
  localparam int KBC_BIT_ENABLE = 3;
  localparam int KBC_BIT_PARITY = 2;
  localparam int KBC_BIT_DATA = 1;
  localparam int KBC_BIT_CLOCK = 0;

  // Interrupt group A status field positions.
  localparam int IRQ_BIT_FORCE = 7;
  localparam int IRQ_BIT_TIMER1 = 6;
  localparam int IRQ_BIT_TIMER0 = 5;
  localparam int IRQ_BIT_POR = 4;
  localparam int IRQ_BIT_VBLANK = 3;
  localparam int IRQ_BIT_EXT1 = 2;
  localparam int IRQ_BIT_EXT2 = 0;
  localparam logic [7:0] IRQ_EDGE_MASK = 8'h6D;

  // Reset values.
  localparam logic [2:0] RST_OPEN_DRAIN = 3'h7;
  localparam logic [7:0] RST_PORT_LINES = 8'hFF;
  localparam logic [7:0] RST_IRQ_MASK = 8'h00;
  localparam logic RST_KBD_ENABLE = 1'b0;

  // Keyboard frame: start, eight data, odd parity, stop.
  localparam int KBD_FRAME_BITS = 11;
  localparam logic [3:0] KBD_LAST_BIT = 4'hA;

  // Serial state machine states.
  typedef enum logic [3:0] {
    KS_IDLE = 4'b0001,
    KS_RX = 4'b0010,
    KS_TX_REQ = 4'b0100,
    KS_TX = 4'b1000
  } kbd_state_t;

  // Host holds the keyboard clock low this long before a send, in ns.
  localparam int KBD_TX_HOLD_NS = 100000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int KBD_TX_HOLD_CYC = (KBD_TX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ---- design/sync_edge.sv ----
// Two-flop synchroniser with rising and falling edge pulses.
module sync_edge
  import io_ctl_pkg::*;
#(
  parameter logic RESET_LEVEL = 1'b0
)
(
  // Clock and control.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Signal.
  input wire logic async_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic meta;
  logic stage;
  logic prev;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      meta <= RESET_LEVEL;
      stage <= RESET_LEVEL;
      prev <= RESET_LEVEL;
    end
    else if (ce_i)
    begin
      meta <= async_i;
      stage <= meta;
      prev <= stage;
    end
  end

  assign level_o = stage;
  assign rise_o = ce_i & stage & ~prev;
  assign fall_o = ce_i & ~stage & prev;

endmodule

// ---- design/kbd_serial.sv ----
// Keyboard serial shifter. Receives device-clocked frames; sends host frames
// after holding the keyboard clock low. Clock edges come from the synchroniser.
module kbd_serial
  import io_ctl_pkg::*;
#(
  parameter int HOLD_CYC = KBD_TX_HOLD_CYC
)
(
  // Clock and control.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic enable_i,
  // Synchronised link.
  input wire logic kclk_fall_i,
  input wire logic kdata_i,
  // Software side.
  input wire logic tx_load_i,
  input wire logic [7:0] tx_byte_i,
  input wire logic rx_taken_i,
  output logic [7:0] rx_byte_o,
  output logic rx_parity_o,
  output logic rx_full_o,
  output logic rx_active_o,
  output logic tx_empty_o,
  output logic tx_active_o,
  // Pin pulls, high means pull low.
  output logic pull_clock_o,
  output logic pull_data_o
);

  // A zero hold would never end the request phase, so refuse it at elaboration.
  if (HOLD_CYC < 1)
  begin : g_bad_hold
    $error("HOLD_CYC must be at least one");
  end

  kbd_state_t state;
  logic [3:0] bitcnt;
  logic [9:0] shreg;
  logic [7:0] txbuf;
  logic tx_pend;
  logic [$clog2(HOLD_CYC+1)-1:0] hold;
  wire logic tx_parity = ~^txbuf;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || (ce_i && !enable_i))
    begin
      state <= KS_IDLE;
      bitcnt <= 4'h0;
      shreg <= 10'h000;
      txbuf <= 8'h00;
      tx_pend <= 1'b0;
      hold <= '0;
      rx_byte_o <= 8'h00;
      rx_parity_o <= 1'b0;
      rx_full_o <= 1'b0;
      pull_clock_o <= 1'b0;
      pull_data_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (rx_taken_i)
        rx_full_o <= 1'b0;
      if (tx_load_i)
      begin
        txbuf <= tx_byte_i;
        tx_pend <= 1'b1;
      end
      case (state)
        KS_IDLE:
        begin
          if (tx_pend)
          begin
            state <= KS_TX_REQ;
            hold <= '0;
            pull_clock_o <= 1'b1;
          end
          else if (kclk_fall_i && !kdata_i)
          begin
            state <= KS_RX;
            bitcnt <= 4'h1;
          end
        end
        KS_RX:
        begin
          if (kclk_fall_i)
          begin
            shreg <= {kdata_i, shreg[9:1]};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == KBD_LAST_BIT)
            begin
              rx_byte_o <= shreg[8:1];
              rx_parity_o <= shreg[9];
              rx_full_o <= 1'b1;
              state <= KS_IDLE;
            end
          end
        end
        KS_TX_REQ:
        begin
          hold <= hold + 1'b1;
          if (32'(hold) == HOLD_CYC - 1)
          begin
            pull_data_o <= 1'b1;
            pull_clock_o <= 1'b0;
            shreg <= {1'b1, tx_parity, txbuf};
            tx_pend <= 1'b0;
            bitcnt <= 4'h1;
            state <= KS_TX;
          end
        end
        KS_TX:
        begin
          if (kclk_fall_i)
          begin
            pull_data_o <= ~shreg[0];
            shreg <= {1'b1, shreg[9:1]};
            bitcnt <= bitcnt + 4'h1;
            if (bitcnt == KBD_LAST_BIT)
            begin
              pull_data_o <= 1'b0;
              state <= KS_IDLE;
            end
          end
        end
        default:
          state <= KS_IDLE;
      endcase
    end
  end

  assign rx_active_o = (state == KS_RX);
  assign tx_active_o = (state == KS_TX_REQ) || (state == KS_TX);
  assign tx_empty_o = enable_i & ~tx_pend & ~tx_active_o;

endmodule

// ---- design/io_control_low_registers.sv ----
module io_control_low_registers
  import io_ctl_pkg::*;
#(
  parameter int HOLD_CYC = KBD_TX_HOLD_CYC
)
(
  // Clock, reset and enable.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic por_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Status sources.
  input wire logic vertical_blank_flag_i,
  input wire logic ext_irq_one_n_i,
  input wire logic ext_irq_two_i,
  input wire logic timer0_i,
  input wire logic timer1_i,
  // Open-drain pins of the I/O control register.
  input wire logic [1:0] open_drain_out_pins_i,
  output logic [1:0] open_drain_out_pins_o,
  output logic [1:0] open_drain_out_pins_oe_n_o,
  input wire logic open_drain_sense_pin_i,
  output logic open_drain_sense_pin_o,
  output logic open_drain_sense_pin_oe_n_o,
  // General port.
  input wire logic [7:0] general_port_pins_i,
  output logic [7:0] general_port_pins_o,
  output logic [7:0] general_port_pins_oe_n_o,
  // Keyboard link.
  input wire logic keyboard_serial_data_pin_i,
  output logic keyboard_serial_data_pin_o,
  output logic keyboard_serial_data_pin_oe_n_o,
  input wire logic keyboard_serial_clock_pin_i,
  output logic keyboard_serial_clock_pin_o,
  output logic keyboard_serial_clock_pin_oe_n_o,
  // Processor interrupt.
  output logic cpu_irq_n_o
);

  import io_ctl_pkg::*;

  logic [2:0] io_control_reg;
  logic [7:0] port_line_reg;
  logic state_machine_on;
  logic force_data_low;
  logic force_clock_low;
  logic [7:0] irq_group_a_status_reg;
  logic [7:0] edge_stat;
  logic por_flag;
  logic [7:0] irq_mask;
  logic por_meta;
  logic por_sync;

  // Synchronised inputs: level, rise, fall.
  logic [14:0] sync_in;
  logic [14:0] sync_lvl;
  logic [14:0] sync_rise;
  logic [14:0] sync_fall;
  assign sync_in = {timer1_i, timer0_i, ext_irq_two_i, ext_irq_one_n_i,
                    vertical_blank_flag_i, keyboard_serial_clock_pin_i,
                    keyboard_serial_data_pin_i, open_drain_sense_pin_i,
                    open_drain_out_pins_i, general_port_pins_i[4:0]};
  logic [2:0] port_hi_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < 15; gi++)
    begin : g_sync
      sync_edge #(.RESET_LEVEL(1'b1)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(sync_in[gi]),
        .level_o(sync_lvl[gi]),
        .rise_o(sync_rise[gi]),
        .fall_o(sync_fall[gi])
      );
    end
    for (gi = 0; gi < 3; gi++)
    begin : g_port_hi
      sync_edge #(.RESET_LEVEL(1'b1)) u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .async_i(general_port_pins_i[gi + 5]),
        .level_o(port_hi_lvl[gi]),
        .rise_o(),
        .fall_o()
      );
    end
  endgenerate

  // Named views of the synchronised levels and edges.
  wire logic [7:0] port_lvl = {port_hi_lvl, sync_lvl[4:0]};
  wire logic [1:0] od_lvl = sync_lvl[6:5];
  wire logic sense_lvl = sync_lvl[7];
  wire logic synced_key_data_level = sync_lvl[8];
  wire logic synced_key_clock_level = sync_lvl[9];
  wire logic key_clock_fall = sync_fall[9];
  wire logic vblank_lvl = sync_lvl[10];
  wire logic vblank_rise = sync_rise[10];
  wire logic ext1_lvl = sync_lvl[11];
  wire logic ext1_fall = sync_fall[11];
  wire logic ext2_rise = sync_rise[12];
  wire logic timer0_rise = sync_rise[13];
  wire logic timer1_rise = sync_rise[14];

  // Address decode.
  wire logic sel_ioc = (addr_i == OFF_IO_CONTROL);
  wire logic sel_kdat = (addr_i == OFF_KEYBOARD_DATA);
  wire logic sel_kctl = (addr_i == OFF_KEYBOARD_CONTROL);
  wire logic sel_port = (addr_i == OFF_PORT_LINES);
  wire logic sel_sta = (addr_i == OFF_IRQ_A_STATUS);
  wire logic sel_req = (addr_i == OFF_IRQ_A_REQUEST);
  wire logic sel_msk = (addr_i == OFF_IRQ_A_MASK);
  wire logic wr_go = wr_i & ce_i;
  wire logic rd_go = rd_i & ce_i;

  // Keyboard shifter.
  logic [7:0] rx_byte;
  logic parity_received;
  logic rx_shift_full;
  logic rx_active;
  logic tx_shift_empty;
  logic tx_active;
  logic pull_clock;
  logic pull_data;

  kbd_serial #(.HOLD_CYC(HOLD_CYC)) u_kbd (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .enable_i(state_machine_on),
    .kclk_fall_i(key_clock_fall),
    .kdata_i(synced_key_data_level),
    .tx_load_i(wr_go & sel_kdat),
    .tx_byte_i(wdata_i),
    .rx_taken_i(rd_go & sel_kdat),
    .rx_byte_o(rx_byte),
    .rx_parity_o(parity_received),
    .rx_full_o(rx_shift_full),
    .rx_active_o(rx_active),
    .tx_empty_o(tx_shift_empty),
    .tx_active_o(tx_active),
    .pull_clock_o(pull_clock),
    .pull_data_o(pull_data)
  );

  // Control registers.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      io_control_reg <= RST_OPEN_DRAIN;
      port_line_reg <= RST_PORT_LINES;
      state_machine_on <= RST_KBD_ENABLE;
      force_data_low <= 1'b0;
      force_clock_low <= 1'b0;
      irq_mask <= RST_IRQ_MASK;
    end
    else if (wr_go)
    begin
      if (sel_ioc)
        io_control_reg <= {wdata_i[IOC_BIT_SENSE], wdata_i[IOC_BIT_OD1],
                           wdata_i[IOC_BIT_OD0]};
      if (sel_port)
        port_line_reg <= wdata_i;
      if (sel_kctl)
      begin
        state_machine_on <= wdata_i[KBC_BIT_ENABLE];
        force_data_low <= wdata_i[KBC_BIT_DATA];
        force_clock_low <= wdata_i[KBC_BIT_CLOCK];
      end
      if (sel_msk)
        irq_mask <= wdata_i;
    end
  end

  // Power-on flag survives the push-button reset; set while power-on is held.
  always_ff @(posedge clk_sys_i)
  begin
    por_meta <= por_n_i;
    por_sync <= por_meta;
  end

  // Edge status. A new edge wins over a clear in the same cycle.
  wire logic [7:0] edge_set = {1'b0, timer1_rise, timer0_rise, 1'b0, vblank_rise,
                               ext1_fall, 1'b0, ext2_rise};
  wire logic [7:0] edge_clr = (wr_go && sel_req) ? (wdata_i & IRQ_EDGE_MASK) : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (!por_sync)
      por_flag <= 1'b1;
    else if (wr_go && sel_req && wdata_i[IRQ_BIT_POR])
      por_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || !por_sync)
      edge_stat <= 8'h00;
    else if (ce_i)
      edge_stat <= (edge_set | (edge_stat & ~edge_clr)) & IRQ_EDGE_MASK;
  end

  // Status is assembled from separately owned flops and fixed bits.
  assign irq_group_a_status_reg = {1'b1, edge_stat[6:5], por_flag, edge_stat[3:2], 1'b0,
                                   edge_stat[0]};

  wire logic [7:0] irq_request = irq_group_a_status_reg & irq_mask;

  // Read views.
  wire logic [7:0] io_control_view = {vblank_lvl, ext1_lvl, 2'b11, sense_lvl, 1'b1,
                                      od_lvl};
  wire logic [7:0] keyboard_control_view = {tx_shift_empty,
                                            tx_active,
                                            rx_shift_full,
                                            rx_active,
                                            state_machine_on,
                                            parity_received,
                                            synced_key_data_level,
                                            synced_key_clock_level};
  wire logic [7:0] read_mux = sel_ioc ? io_control_view :
                              sel_kdat ? rx_byte :
                              sel_kctl ? keyboard_control_view :
                              sel_port ? port_lvl :
                              sel_sta ? irq_group_a_status_reg :
                              sel_req ? irq_request :
                              sel_msk ? irq_mask : 8'h00;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (rd_go)
      rdata_o <= read_mux;
  end

  // Pin drive: outputs always low, enable low while pulling.
  assign open_drain_out_pins_o = 2'b00;
  assign open_drain_out_pins_oe_n_o = io_control_reg[1:0];
  assign open_drain_sense_pin_o = 1'b0;
  assign open_drain_sense_pin_oe_n_o = io_control_reg[2];
  assign general_port_pins_o = 8'h00;
  assign general_port_pins_oe_n_o = port_line_reg;
  assign keyboard_serial_data_pin_o = 1'b0;
  assign keyboard_serial_data_pin_oe_n_o = ~(force_data_low | pull_data);
  assign keyboard_serial_clock_pin_o = 1'b0;
  assign keyboard_serial_clock_pin_oe_n_o = ~(force_clock_low | pull_clock);
  assign cpu_irq_n_o = ~|irq_request;

endmodule

// ---- verification/io_control_low_registers_properties.sv ----
module io_control_low_registers_properties
  import io_ctl_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Pins and interrupt.
  input wire logic [1:0] open_drain_out_pins_o,
  input wire logic [1:0] open_drain_out_pins_oe_n_o,
  input wire logic open_drain_sense_pin_oe_n_o,
  input wire logic [7:0] general_port_pins_o,
  input wire logic [7:0] general_port_pins_oe_n_o,
  input wire logic keyboard_serial_data_pin_oe_n_o,
  input wire logic keyboard_serial_clock_pin_oe_n_o,
  input wire logic cpu_irq_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire ioc_wr = wr_i && ce_i && addr_i == OFF_IO_CONTROL;
  wire kbc_wr = wr_i && ce_i && addr_i == OFF_KEYBOARD_CONTROL;
  sequence port_write;
    wr_i && ce_i && addr_i == OFF_PORT_LINES;
  endsequence
  sequence mask_force;
    wr_i && ce_i && addr_i == OFF_IRQ_A_MASK && wdata_i[IRQ_BIT_FORCE];
  endsequence
  chk_reset_release: assert property (
    $rose(rst_n_i) |-> (&open_drain_out_pins_oe_n_o) && open_drain_sense_pin_oe_n_o
      && (&general_port_pins_oe_n_o)) else $error("pins not released after reset");
  // An open-drain pin may only pull low, so the data outputs never carry a one.
  chk_pins_low_only: assert property (
    open_drain_out_pins_o == 2'h0 && general_port_pins_o == 8'h00)
    else $error("open-drain data output high");
  chk_ioc_write: assert property (
    ioc_wr |=> open_drain_out_pins_oe_n_o == $past(wdata_i[1:0])
      && open_drain_sense_pin_oe_n_o == $past(wdata_i[3])) else $error("io control pin drive");
  chk_port_write: assert property (
    port_write |=> general_port_pins_oe_n_o == $past(wdata_i)) else $error("port drive");
  chk_port_hold: assert property (
    !(wr_i && addr_i == OFF_PORT_LINES) |=> $stable(general_port_pins_oe_n_o))
    else $error("port drive changed without write");
  chk_ioc_fixed_ones: assert property (
    rd_i && ce_i && addr_i == OFF_IO_CONTROL |=> rdata_o[5:4] == 2'b11 && rdata_o[2])
    else $error("io control constant bits");
  chk_status_fixed: assert property (
    rd_i && ce_i && addr_i == OFF_IRQ_A_STATUS |=> rdata_o[7] && !rdata_o[1])
    else $error("status constant bits");
  chk_irq_force: assert property (
    mask_force |=> !cpu_irq_n_o) else $error("forced interrupt missing");
  chk_kbd_force_pull: assert property (
    kbc_wr |=> (!$past(wdata_i[0]) || !keyboard_serial_clock_pin_oe_n_o)
      && (!$past(wdata_i[1]) || !keyboard_serial_data_pin_oe_n_o))
    else $error("keyboard pin not pulled");
endmodule

// ---- verification/kbd_model.sv ----
module kbd_model
(
  // Host pulls, low means pulled.
  input wire logic d_oe_n_i,
  input wire logic c_oe_n_i,
  // Resolved lines.
  output logic kdata_o,
  output logic kclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic kd = 1'b1;
  logic kc = 1'b1;
  // Both lines carry pull-ups, so a line nobody pulls reads high.
  assign kdata_o = d_oe_n_i & kd;
  assign kclk_o = c_oe_n_i & kc;
  // One 160 ns link clock period; the clock stands high outside frames.
  task automatic pulse();
    #40 kc = 1'b0;
    #80 kc = 1'b1;
    #40;
  endtask
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {1'b1, ~^b, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      kd = f[i];
      pulse();
    end
    kd = 1'b1;
  endtask
  // Waits for the host start condition, then clocks its frame in.
  task automatic recv(output logic [9:0] got);
    int n;
    got = 10'h000;
    for (n = 0; n < 2000 && !(!d_oe_n_i && c_oe_n_i); n++) #8;
    for (int i = 0; i < 11; i++)
    begin
      pulse();
      if (i < 10) got[i] = kdata_o;
    end
  endtask
endmodule

// ---- verification/io_control_low_registers_tb.sv ----
module io_control_low_registers_tb;
  import io_ctl_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por_n = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic vb = 1'b0;
  logic e1n = 1'b1;
  logic e2 = 1'b0;
  logic t0 = 1'b0;
  logic t1 = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] gp_ext = 8'h00;
  logic [7:0] rdata, gp_oe_n;
  logic [1:0] od_oe_n;
  logic id_oe_n, kd_oe_n, kc_oe_n, kdata, kclk, irq_n;
  int error_cnt = 0;
  int num_checks = 0;
  int cycles = 0;
  always #4 clk = ~clk;
  io_control_low_registers #(.HOLD_CYC(4)) dut (
    .clk_sys_i(clk), .rst_n_i(rst_n), .por_n_i(por_n), .ce_i(1'b1),
    .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .vertical_blank_flag_i(vb), .ext_irq_one_n_i(e1n), .ext_irq_two_i(e2),
    .timer0_i(t0), .timer1_i(t1),
    .open_drain_out_pins_i(od_oe_n), .open_drain_out_pins_o(),
    .open_drain_out_pins_oe_n_o(od_oe_n),
    .open_drain_sense_pin_i(id_oe_n), .open_drain_sense_pin_o(),
    .open_drain_sense_pin_oe_n_o(id_oe_n),
    .general_port_pins_i(gp_oe_n & ~gp_ext), .general_port_pins_o(),
    .general_port_pins_oe_n_o(gp_oe_n),
    .keyboard_serial_data_pin_i(kdata), .keyboard_serial_data_pin_o(),
    .keyboard_serial_data_pin_oe_n_o(kd_oe_n),
    .keyboard_serial_clock_pin_i(kclk), .keyboard_serial_clock_pin_o(),
    .keyboard_serial_clock_pin_oe_n_o(kc_oe_n), .cpu_irq_n_o(irq_n));
  kbd_model kbd (.d_oe_n_i(kd_oe_n), .c_oe_n_i(kc_oe_n), .kdata_o(kdata), .kclk_o(kclk));
  task automatic summarize();
    if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // The whole sequence needs some 850 cycles; the ceiling leaves ample room.
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end
  task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
    num_checks++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                        input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(n, rdata & m, e);
  endtask
  task automatic do_reset(input logic p);
    @(posedge clk);
    rst_n <= 1'b0;
    por_n <= ~p;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    por_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic t_reset();
    check("od_oe", {5'h00, id_oe_n, od_oe_n}, 8'h07);
    check("gp_oe", gp_oe_n, 8'hFF);
    rd_chk(OFF_IO_CONTROL, 8'hFF, 8'h7F, "ioc");
    rd_chk(OFF_PORT_LINES, 8'hFF, 8'hFF, "port");
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'h90, "status");
    rd_chk(8'h40, 8'hFF, 8'h00, "unmapped");
  endtask
  task automatic t_ioc();
    wr_reg(OFF_IO_CONTROL, 8'hF4);
    check("od_oe", {5'h00, id_oe_n, od_oe_n}, 8'h00);
    repeat (3) @(posedge clk);
    rd_chk(OFF_IO_CONTROL, 8'hFF, 8'h74, "ioc");
    wr_reg(OFF_IO_CONTROL, 8'h0A);
    repeat (3) @(posedge clk);
    rd_chk(OFF_IO_CONTROL, 8'hFF, 8'h7E, "ioc");
  endtask
  task automatic t_port();
    gp_ext <= 8'h01;
    wr_reg(OFF_PORT_LINES, 8'hA5);
    check("gp_oe", gp_oe_n, 8'hA5);
    repeat (3) @(posedge clk);
    rd_chk(OFF_PORT_LINES, 8'hFF, 8'hA4, "port");
    gp_ext <= 8'h00;
  endtask
  task automatic t_status();
    @(posedge clk);
    {t1, t0, vb, e2, e1n} <= 5'b11110;
    repeat (5) @(posedge clk);
    rd_chk(OFF_IO_CONTROL, 8'hC0, 8'h80, "ioc_live");
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'hFD, "status");
    wr_reg(OFF_IRQ_A_STATUS, 8'h00);
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'hFD, "status");
    rd_chk(OFF_IRQ_A_REQUEST, 8'hFF, 8'h00, "request");
    wr_reg(OFF_IRQ_A_MASK, 8'h04);
    check("irq_n", {7'h00, irq_n}, 8'h00);
    rd_chk(OFF_IRQ_A_REQUEST, 8'hFF, 8'h04, "request");
    // Sources still asserted: a held level must not set the bits again.
    wr_reg(OFF_IRQ_A_REQUEST, 8'h6D);
    repeat (4) @(posedge clk);
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'h90, "status");
    check("irq_n", {7'h00, irq_n}, 8'h01);
    {t1, t0, vb, e2, e1n} <= 5'b00001;
    repeat (5) @(posedge clk);
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'h90, "status");
    wr_reg(OFF_IRQ_A_MASK, 8'h80);
    check("irq_n", {7'h00, irq_n}, 8'h00);
    wr_reg(OFF_IRQ_A_MASK, 8'h00);
    check("irq_n", {7'h00, irq_n}, 8'h01);
  endtask
  task automatic t_por();
    wr_reg(OFF_IRQ_A_REQUEST, 8'h10);
    wr_reg(OFF_IO_CONTROL, 8'h00);
    do_reset(1'b0);
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'h80, "status");
    check("od_oe", {5'h00, id_oe_n, od_oe_n}, 8'h07);
    check("gp_oe", gp_oe_n, 8'hFF);
    do_reset(1'b1);
    rd_chk(OFF_IRQ_A_STATUS, 8'hFF, 8'h90, "status");
  endtask
  task automatic t_kbd();
    logic [7:0] bytes [2] = '{8'hA5, 8'h07};
    logic [9:0] got;
    wr_reg(OFF_KEYBOARD_CONTROL, 8'h08);
    repeat (3) @(posedge clk);
    rd_chk(OFF_KEYBOARD_CONTROL, 8'hFB, 8'h8B, "kctl");
    foreach (bytes[i])
    begin
      fork
        kbd.send(bytes[i]);
        #600 rd_chk(OFF_KEYBOARD_CONTROL, 8'h30, 8'h10, "rx_busy");
      join
      repeat (5) @(posedge clk);
      rd_chk(OFF_KEYBOARD_CONTROL, 8'h34, 8'h20 | {5'h00, ~^bytes[i], 2'h0}, "kctl");
      rd_chk(OFF_KEYBOARD_DATA, 8'hFF, bytes[i], "kdata");
    end
    wr_reg(OFF_KEYBOARD_DATA, 8'h3C);
    fork
      kbd.recv(got);
      #900 rd_chk(OFF_KEYBOARD_CONTROL, 8'hC0, 8'h40, "tx_busy");
    join
    check("tx_byte", got[7:0], 8'h3C);
    check("tx_par", {7'h00, got[8]}, {7'h00, ~^8'h3C});
    repeat (10) @(posedge clk);
    rd_chk(OFF_KEYBOARD_CONTROL, 8'hC8, 8'h88, "kctl");
    wr_reg(OFF_KEYBOARD_CONTROL, 8'h0B);
    check("kpull", {6'h00, kd_oe_n, kc_oe_n}, 8'h00);
    repeat (3) @(posedge clk);
    rd_chk(OFF_KEYBOARD_CONTROL, 8'h0B, 8'h08, "kpins");
    wr_reg(OFF_KEYBOARD_CONTROL, 8'h00);
    rd_chk(OFF_KEYBOARD_CONTROL, 8'h88, 8'h00, "kctl");
  endtask
  initial
  begin
    do_reset(1'b1);
    t_reset();
    t_ioc();
    t_port();
    t_status();
    t_por();
    t_kbd();
    summarize();
  end
endmodule

bind io_control_low_registers io_control_low_registers_properties props (.*);
